// ---- logic/pixel_correction_pkg.sv ----
`default_nettype none
package pixel_correction_pkg;
   localparam int PIX_W = 12;
   localparam int ADDR_W = 16;
   localparam int COORD_W = 12;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_BANK_SELECT = 16'h0410;
   localparam logic [ADDR_W-1:0] OFS_TABLE_ENABLE = 16'h0414;
   localparam logic [ADDR_W-1:0] OFS_DEFECT_MODE = 16'h0418;
   localparam logic [ADDR_W-1:0] OFS_HOT_MODE = 16'h041c;
   localparam logic [ADDR_W-1:0] OFS_DEFECT_THR = 16'h042c;
   localparam logic [ADDR_W-1:0] OFS_HOT_THR = 16'h0430;
   localparam logic [ADDR_W-1:0] OFS_DEFECT_COUNT = 16'h0434;
   localparam logic [ADDR_W-1:0] OFS_HOT_COUNT = 16'h0438;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 16'h043c;

   // Memory windows, selected by the upper address bits
   localparam logic [1:0] WIN_LUT_A = 2'h1;
   localparam logic [1:0] WIN_LUT_B = 2'h2;
   localparam logic [3:0] WIN_DEFECT_MAP = 4'hc;
   localparam logic [3:0] WIN_HOT_MAP = 4'hd;

   // Map entry word layout
   localparam int COL_LSB = 0;
   localparam int ROW_LSB = 16;

   // Reset values
   localparam logic RST_BANK = 1'b0;
   localparam logic RST_TABLE_EN = 1'b0;
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic [PIX_W-1:0] RST_THR = 12'h000;

   // Correction mode bits
   localparam int MODE_STATIC_BIT = 0;
   localparam int MODE_DYNAMIC_BIT = 1;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eol;
      logic [PIX_W-1:0] data;
   } pixel_t;

   typedef struct packed {
      logic [COORD_W-1:0] row;
      logic [COORD_W-1:0] col;
   } coord_t;
endpackage
`default_nettype wire

// ---- logic/pixel_data_correction.sv ----
`timescale 1ns/10ps
`default_nettype none

module correction_stage #(
   parameter int DEPTH = 128,
   parameter int IDX_W = $clog2(DEPTH),
   parameter int CNT_W = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] mode,
   input wire logic [pixel_correction_pkg::PIX_W-1:0] thr,
   input wire logic [CNT_W-1:0] map_count,
   input wire logic map_we,
   input wire logic [IDX_W-1:0] map_idx,
   input wire pixel_correction_pkg::coord_t map_wdata,
   input wire pixel_correction_pkg::pixel_t pix_in,
   output pixel_correction_pkg::pixel_t pix_out,
   output logic fix_pulse
);
   import pixel_correction_pkg::*;

   function automatic logic [PIX_W-1:0] abs_diff(input logic [PIX_W-1:0] a,
                                                 input logic [PIX_W-1:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   coord_t map_mem [DEPTH];
   logic [COORD_W-1:0] col_reg;
   logic [COORD_W-1:0] row_reg;
   logic [CNT_W-1:0] idx_reg;
   logic [PIX_W-1:0] left1_reg;
   logic [PIX_W-1:0] left2_reg;

   wire logic [COORD_W-1:0] col_now = pix_in.sof ? '0 : col_reg;
   wire logic [COORD_W-1:0] row_now = pix_in.sof ? '0 : row_reg;
   wire logic [CNT_W-1:0] idx_now = pix_in.sof ? '0 : idx_reg;
   wire logic in_range = idx_now < map_count;
   wire coord_t entry = map_mem[idx_now[IDX_W-1:0]];
   wire logic [2*COORD_W-1:0] pos = {row_now, col_now};
   wire logic advance = in_range && ({entry.row, entry.col} <= pos);
   wire logic hit = mode[MODE_STATIC_BIT] && in_range && ({entry.row, entry.col} == pos);
   wire logic has_left2 = col_now >= COORD_W'(2);
   wire logic dyn = mode[MODE_DYNAMIC_BIT] && has_left2 &&
                    (abs_diff(pix_in.data, left1_reg) > thr) &&
                    (abs_diff(pix_in.data, left2_reg) > thr);
   wire logic fix = (hit || dyn) && (col_now != '0);
   wire logic [PIX_W-1:0] data_next = fix ? left1_reg : pix_in.data;

   always_ff @(posedge mclk) begin
      if (map_we) begin
         map_mem[map_idx] <= map_wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         col_reg <= '0;
         row_reg <= '0;
         idx_reg <= '0;
         left1_reg <= '0;
         left2_reg <= '0;
         pix_out <= '0;
         fix_pulse <= 1'b0;
      end else begin
         pix_out <= '{pix_in.valid, pix_in.sof, pix_in.eol, data_next};
         fix_pulse <= pix_in.valid && fix;
         if (pix_in.valid) begin
            col_reg <= pix_in.eol ? '0 : col_now + COORD_W'(1);
            row_reg <= pix_in.eol ? row_now + COORD_W'(1) : row_now;
            idx_reg <= advance ? idx_now + CNT_W'(1) : idx_now;
            left1_reg <= data_next;
            left2_reg <= left1_reg;
         end
      end
   end

   property p_dynamic_replace;
      @(posedge mclk) disable iff (rst)
      (pix_in.valid && dyn && col_now != '0) |=> (pix_out.data == $past(left1_reg));
   endproperty
   a_dynamic_replace: assert property (p_dynamic_replace) else $error("dynamic fix not applied");

   property p_static_walk;
      @(posedge mclk) disable iff (rst)
      (pix_in.valid && hit) |=> (idx_reg == $past(idx_now) + CNT_W'(1)) && pix_out.valid;
   endproperty
   a_static_walk: assert property (p_static_walk) else $error("map walk did not advance");
endmodule

module pixel_data_correction #(
   parameter int LUT_DEPTH = 4096,
   parameter int DEFECT_DEPTH = 128,
   parameter int HOT_DEPTH = 1024
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [pixel_correction_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pixel_correction_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pixel_correction_pkg::pixel_t pix_in,
   output pixel_correction_pkg::pixel_t pix_out
);
   import pixel_correction_pkg::*;

   localparam int LUT_IDX_W = $clog2(LUT_DEPTH);
   localparam int DIDX_W = $clog2(DEFECT_DEPTH);
   localparam int HIDX_W = $clog2(HOT_DEPTH);
   localparam int DCNT_W = $clog2(DEFECT_DEPTH + 1);
   localparam int HCNT_W = $clog2(HOT_DEPTH + 1);

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction

   logic bank_sel_reg;
   logic table_en_reg;
   logic [1:0] defect_mode_reg;
   logic [1:0] hot_mode_reg;
   logic [PIX_W-1:0] defect_thr_reg;
   logic [PIX_W-1:0] hot_thr_reg;
   logic [DCNT_W-1:0] defect_count_reg;
   logic [HCNT_W-1:0] hot_count_reg;
   logic [15:0] defect_fixes_reg;
   logic [15:0] hot_fixes_reg;
   logic [PIX_W-1:0] lut_a [LUT_DEPTH];
   logic [PIX_W-1:0] lut_b [LUT_DEPTH];
   pixel_t lut_out_reg;
   pixel_t defect_out;
   logic defect_fix;
   logic hot_fix;

   // Write decode; address and data are taken together
   wire logic wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire logic [ADDR_W-1:0] wa = s_axi_awaddr;
   wire logic w_bank = wa == OFS_BANK_SELECT;
   wire logic w_table_en = wa == OFS_TABLE_ENABLE;
   wire logic w_dmode = wa == OFS_DEFECT_MODE;
   wire logic w_hmode = wa == OFS_HOT_MODE;
   wire logic w_dthr = wa == OFS_DEFECT_THR;
   wire logic w_hthr = wa == OFS_HOT_THR;
   wire logic w_dcount = wa == OFS_DEFECT_COUNT;
   wire logic w_hcount = wa == OFS_HOT_COUNT;
   wire logic w_status = wa == OFS_STATUS;
   wire logic w_lut_a = wa[15:14] == WIN_LUT_A;
   wire logic w_lut_b = wa[15:14] == WIN_LUT_B;
   wire logic w_dmap = (wa[15:12] == WIN_DEFECT_MAP) && (wa[11:DIDX_W+2] == '0);
   wire logic w_hmap = wa[15:12] == WIN_HOT_MAP;
   wire logic w_hit = w_bank || w_table_en || w_dmode || w_hmode || w_dthr || w_hthr ||
                      w_dcount || w_hcount || w_status || w_lut_a || w_lut_b ||
                      w_dmap || w_hmap;
   wire logic mem_we = wr_take && (s_axi_wstrb != 4'h0);
   wire coord_t map_wdata = '{s_axi_wdata[ROW_LSB +: COORD_W], s_axi_wdata[COL_LSB +: COORD_W]};

   wire logic [31:0] wd_bank = merge(32'(bank_sel_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_table_en = merge(32'(table_en_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_dmode = merge(32'(defect_mode_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_hmode = merge(32'(hot_mode_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_dthr = merge(32'(defect_thr_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_hthr = merge(32'(hot_thr_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_dcount = merge(32'(defect_count_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [31:0] wd_hcount = merge(32'(hot_count_reg), s_axi_wdata, s_axi_wstrb);
   wire logic [DCNT_W-1:0] dcount_next = (wd_dcount > 32'(DEFECT_DEPTH)) ?
                                         DCNT_W'(DEFECT_DEPTH) : wd_dcount[DCNT_W-1:0];
   wire logic [HCNT_W-1:0] hcount_next = (wd_hcount > 32'(HOT_DEPTH)) ?
                                         HCNT_W'(HOT_DEPTH) : wd_hcount[HCNT_W-1:0];

   // Read decode
   wire logic rd_take = s_axi_arvalid && !s_axi_rvalid;
   wire logic [ADDR_W-1:0] ra = s_axi_araddr;
   wire logic r_window = (ra[15:14] == WIN_LUT_A) || (ra[15:14] == WIN_LUT_B) ||
                         ((ra[15:12] == WIN_DEFECT_MAP) && (ra[11:DIDX_W+2] == '0)) ||
                         (ra[15:12] == WIN_HOT_MAP);
   wire logic [31:0] rd_word =
      (ra == OFS_BANK_SELECT) ? 32'(bank_sel_reg) :
      (ra == OFS_TABLE_ENABLE) ? 32'(table_en_reg) :
      (ra == OFS_DEFECT_MODE) ? 32'(defect_mode_reg) :
      (ra == OFS_HOT_MODE) ? 32'(hot_mode_reg) :
      (ra == OFS_DEFECT_THR) ? 32'(defect_thr_reg) :
      (ra == OFS_HOT_THR) ? 32'(hot_thr_reg) :
      (ra == OFS_DEFECT_COUNT) ? 32'(defect_count_reg) :
      (ra == OFS_HOT_COUNT) ? 32'(hot_count_reg) :
      (ra == OFS_STATUS) ? {hot_fixes_reg, defect_fixes_reg} : 32'h0000_0000;
   wire logic r_hit = r_window || (ra == OFS_BANK_SELECT) || (ra == OFS_TABLE_ENABLE) ||
                      (ra == OFS_DEFECT_MODE) || (ra == OFS_HOT_MODE) ||
                      (ra == OFS_DEFECT_THR) || (ra == OFS_HOT_THR) ||
                      (ra == OFS_DEFECT_COUNT) || (ra == OFS_HOT_COUNT) || (ra == OFS_STATUS);

   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = !s_axi_rvalid;

   // Table read for the incoming pixel
   wire logic [PIX_W-1:0] lut_a_rd = lut_a[pix_in.data[LUT_IDX_W-1:0]];
   wire logic [PIX_W-1:0] lut_b_rd = lut_b[pix_in.data[LUT_IDX_W-1:0]];
   wire logic [PIX_W-1:0] lut_sel_rd = bank_sel_reg ? lut_b_rd : lut_a_rd;
   wire logic [PIX_W-1:0] lut_data = table_en_reg ? lut_sel_rd : pix_in.data;

   always_ff @(posedge mclk) begin
      if (mem_we && w_lut_a) begin
         lut_a[wa[LUT_IDX_W+1:2]] <= s_axi_wdata[PIX_W-1:0];
      end
      if (mem_we && w_lut_b) begin
         lut_b[wa[LUT_IDX_W+1:2]] <= s_axi_wdata[PIX_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bank_sel_reg <= RST_BANK;
         table_en_reg <= RST_TABLE_EN;
         defect_mode_reg <= RST_MODE;
         hot_mode_reg <= RST_MODE;
         defect_thr_reg <= RST_THR;
         hot_thr_reg <= RST_THR;
         defect_count_reg <= '0;
         hot_count_reg <= '0;
      end else if (wr_take) begin
         if (w_bank) bank_sel_reg <= wd_bank[0];
         if (w_table_en) table_en_reg <= wd_table_en[0];
         if (w_dmode) defect_mode_reg <= wd_dmode[1:0];
         if (w_hmode) hot_mode_reg <= wd_hmode[1:0];
         if (w_dthr) defect_thr_reg <= wd_dthr[PIX_W-1:0];
         if (w_hthr) hot_thr_reg <= wd_hthr[PIX_W-1:0];
         if (w_dcount) defect_count_reg <= dcount_next;
         if (w_hcount) hot_count_reg <= hcount_next;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
      end else begin
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= r_hit ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= rd_word;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lut_out_reg <= '0;
         defect_fixes_reg <= '0;
         hot_fixes_reg <= '0;
      end else begin
         lut_out_reg <= '{pix_in.valid, pix_in.sof, pix_in.eol, lut_data};
         defect_fixes_reg <= defect_fixes_reg + 16'(defect_fix);
         hot_fixes_reg <= hot_fixes_reg + 16'(hot_fix);
      end
   end

   correction_stage #(.DEPTH(DEFECT_DEPTH)) defect_correction (
      .mclk(mclk),
      .rst(rst),
      .mode(defect_mode_reg),
      .thr(defect_thr_reg),
      .map_count(defect_count_reg),
      .map_we(mem_we && w_dmap),
      .map_idx(wa[DIDX_W+1:2]),
      .map_wdata(map_wdata),
      .pix_in(lut_out_reg),
      .pix_out(defect_out),
      .fix_pulse(defect_fix)
   );

   correction_stage #(.DEPTH(HOT_DEPTH)) hot_correction (
      .mclk(mclk),
      .rst(rst),
      .mode(hot_mode_reg),
      .thr(hot_thr_reg),
      .map_count(hot_count_reg),
      .map_we(mem_we && w_hmap),
      .map_idx(wa[HIDX_W+1:2]),
      .map_wdata(map_wdata),
      .pix_in(defect_out),
      .pix_out(pix_out),
      .fix_pulse(hot_fix)
   );

   property p_table_second;
      @(posedge mclk) disable iff (rst)
      (pix_in.valid && table_en_reg && bank_sel_reg) |=> (lut_out_reg.data == $past(lut_b_rd));
   endproperty
   a_table_second: assert property (p_table_second) else $error("second table not used");

   property p_table_bypass;
      @(posedge mclk) disable iff (rst)
      (pix_in.valid && !table_en_reg) |=> (lut_out_reg.data == $past(pix_in.data));
   endproperty
   a_table_bypass: assert property (p_table_bypass) else $error("bypass altered pixel");

   property p_defect_off;
      @(posedge mclk) disable iff (rst)
      (lut_out_reg.valid && defect_mode_reg == 2'h0) |=>
         (defect_out.valid && defect_out.data == $past(lut_out_reg.data));
   endproperty
   a_defect_off: assert property (p_defect_off) else $error("defect stage changed pixel");

   property p_hot_off;
      @(posedge mclk) disable iff (rst)
      (defect_out.valid && hot_mode_reg == 2'h0) |=>
         (pix_out.valid && pix_out.data == $past(defect_out.data));
   endproperty
   a_hot_off: assert property (p_hot_off) else $error("hot stage changed pixel");

   property p_table_window;
      @(posedge mclk) disable iff (rst)
      (wr_take && (w_lut_a || w_lut_b)) |=> (s_axi_bvalid && s_axi_bresp == RESP_OKAY);
   endproperty
   a_table_window: assert property (p_table_window) else $error("table write refused");

   property p_stream_latency;
      @(posedge mclk) disable iff (rst)
      (pix_in.valid && pix_in.sof) |-> ##3 (pix_out.valid && pix_out.sof);
   endproperty
   a_stream_latency: assert property (p_stream_latency) else $error("pixel lost in stream");

   property p_map_limit;
      @(posedge mclk) disable iff (rst)
      (wr_take && w_dcount && wd_dcount > 32'(DEFECT_DEPTH)) |=>
         (defect_count_reg == DCNT_W'(DEFECT_DEPTH));
   endproperty
   a_map_limit: assert property (p_map_limit) else $error("defect map count above limit");
endmodule

`default_nettype wire

// ---- test/pixel_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module pixel_source (
   input wire logic mclk,
   output pixel_correction_pkg::pixel_t pix_in,
   input wire pixel_correction_pkg::pixel_t pix_out
);
   import pixel_correction_pkg::*;
   logic [PIX_W-1:0] got[$];

   initial pix_in = '0;

   // Collects each corrected pixel as the formatter would
   always @(posedge mclk) begin
      if (pix_out.valid === 1'b1) begin
         got.push_back(pix_out.data);
      end
   end

   // Sends a one-line frame without gaps; idle data is inverted, never held
   task automatic send(input logic [PIX_W-1:0] v[$]);
      for (int i = 0; i < v.size(); i++) begin
         @(posedge mclk);
         pix_in <= '{valid: 1'b1, sof: (i == 0), eol: (i == v.size() - 1), data: v[i]};
      end
      @(posedge mclk);
      pix_in <= '{valid: 1'b0, sof: 1'b0, eol: 1'b0, data: ~v[v.size() - 1]};
      repeat (5) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// ---- test/test_pixel_data_correction.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_pixel_data_correction;
   import pixel_correction_pkg::*;
   logic mclk;
   logic rst;
   logic [ADDR_W-1:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [ADDR_W-1:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   pixel_t pix_in;
   pixel_t pix_out;
   int miscompares = 0;
   int checked = 0;
   logic [ADDR_W-1:0] ofs[6] = '{OFS_BANK_SELECT, OFS_TABLE_ENABLE, OFS_DEFECT_MODE,
      OFS_HOT_MODE, OFS_DEFECT_THR, OFS_HOT_THR};
   logic [31:0] val[6] = '{32'h1, 32'h1, 32'h3, 32'h2, 32'hfff, 32'habc};

   pixel_data_correction uut (.mclk(mclk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pix_in(pix_in),
      .pix_out(pix_out));

   pixel_source src (.mclk(mclk), .pix_in(pix_in), .pix_out(pix_out));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Address and data offered together; bready held until the response
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic axi_read(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge mclk);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, ed);
      check({30'h0, s_axi_rresp}, {30'h0, er});
   endtask

   task automatic cmp_line(input logic [PIX_W-1:0] e[$]);
      check(32'(src.got.size()), 32'(e.size()));
      for (int i = 0; i < e.size() && i < src.got.size(); i++) begin
         check({20'h0, src.got[i]}, {20'h0, e[i]});
      end
      src.got.delete();
   endtask

   initial begin
      #100us;
      miscompares++;
      end_of_test;
   end

   initial begin
      rst = 1'b1;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) axi_read(ofs[i], 32'h0, RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         axi_write(ofs[i], val[i], RESP_OKAY);
         axi_read(ofs[i], val[i], RESP_OKAY);
      end
      for (int i = 0; i < 6; i++) axi_write(ofs[i], 32'h0, RESP_OKAY);
      axi_write(16'h0500, 32'h1, RESP_SLVERR);
      axi_read(16'h0500, 32'h0, RESP_SLVERR);
      axi_write(OFS_DEFECT_COUNT, 32'h0c8, RESP_OKAY);
      axi_read(OFS_DEFECT_COUNT, 32'h080, RESP_OKAY);
      axi_write(OFS_HOT_COUNT, 32'h7d0, RESP_OKAY);
      axi_read(OFS_HOT_COUNT, 32'h400, RESP_OKAY);
      $display("test registers done");
      axi_write(OFS_DEFECT_THR, 32'h010, RESP_OKAY);
      axi_write(OFS_DEFECT_MODE, 32'h2, RESP_OKAY);
      src.send('{12'h064, 12'h064, 12'h074, 12'h1f4, 12'h064});
      cmp_line('{12'h064, 12'h064, 12'h074, 12'h074, 12'h064});
      axi_write(16'hc000, 32'h0000_0001, RESP_OKAY);
      axi_write(OFS_DEFECT_COUNT, 32'h1, RESP_OKAY);
      axi_write(OFS_DEFECT_MODE, 32'h3, RESP_OKAY);
      src.send('{12'h064, 12'h0c8, 12'h074, 12'h1f4, 12'h064});
      cmp_line('{12'h064, 12'h064, 12'h074, 12'h074, 12'h064});
      axi_write(OFS_DEFECT_MODE, 32'h0, RESP_OKAY);
      src.send('{12'h064, 12'h064, 12'h074, 12'h1f4, 12'h064});
      cmp_line('{12'h064, 12'h064, 12'h074, 12'h1f4, 12'h064});
      $display("test dynamic done");
      axi_write(16'hd000, 32'h0000_0001, RESP_OKAY);
      axi_write(16'hd004, 32'h0000_0003, RESP_OKAY);
      axi_write(OFS_HOT_COUNT, 32'h2, RESP_OKAY);
      axi_write(OFS_HOT_MODE, 32'h1, RESP_OKAY);
      src.send('{12'h00a, 12'h0c8, 12'h01e, 12'h3e7, 12'h028});
      cmp_line('{12'h00a, 12'h00a, 12'h01e, 12'h01e, 12'h028});
      axi_write(OFS_HOT_MODE, 32'h0, RESP_OKAY);
      $display("test static done");
      axi_write(16'h4014, 32'h0aa, RESP_OKAY);
      axi_write(16'h7ffc, 32'h123, RESP_OKAY);
      axi_write(16'h8014, 32'h0bb, RESP_OKAY);
      axi_write(16'hbffc, 32'h456, RESP_OKAY);
      src.send('{12'h005, 12'hfff});
      cmp_line('{12'h005, 12'hfff});
      axi_write(OFS_TABLE_ENABLE, 32'h1, RESP_OKAY);
      src.send('{12'h005, 12'hfff});
      cmp_line('{12'h0aa, 12'h123});
      axi_write(OFS_BANK_SELECT, 32'h1, RESP_OKAY);
      src.send('{12'h005, 12'hfff});
      cmp_line('{12'h0bb, 12'h456});
      $display("test table done");
      axi_read(OFS_STATUS, 32'h0002_0003, RESP_OKAY);
      end_of_test;
   end
endmodule
`default_nettype wire
